// ### design/port_irq_regs.vh
/*
  register indices, reset values, state codes and timing counts of the
  port edge interrupt block. assumes apb byte address = index * 4.
*/
`ifndef PORT_IRQ_REGS_VH
`define PORT_IRQ_REGS_VH

// ----------------------------------------------------------------
// register indices
// ----------------------------------------------------------------
`define IDX_PORT_OUTPUT_LATCH    16'h7f54
`define IDX_PORT_PIN_INPUT       16'h7f55
`define IDX_PORT_DIRECTION       16'h7f56
`define IDX_IRQ_PIN_SELECT       16'h7f57
`define IDX_SAMPLE_CLOCK_SELECT  16'h7fe5
`define IDX_PIN_IRQ_FLAGS        16'h7fee
`define IDX_WAKE_STATUS          16'h7fef

// ----------------------------------------------------------------
// reset values and widths
// ----------------------------------------------------------------
`define RST_BYTE                 8'h00
`define ADDR_W                   18
`define ADDR_LSB                 2'h0

// ----------------------------------------------------------------
// detection modes {direction, latch}
// ----------------------------------------------------------------
`define MODE_NONE                2'h0
`define MODE_FALL                2'h1
`define MODE_RISE                2'h2
`define MODE_BOTH                2'h3

// ----------------------------------------------------------------
// power states
// ----------------------------------------------------------------
`define ST_RUN                   2'h0
`define ST_STBY                  2'h1
`define ST_DEEP                  2'h2
`define ST_IDLE                  2'h3

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define FILTER_LAST              3'h7
`define CLK_PERIOD_NS            20
`define BT_PERIOD_NS             30518
`define BT_DIV                   (`BT_PERIOD_NS / `CLK_PERIOD_NS)
`define BT_CNT_W                 11

`endif

// ### design/base_tick_gen.v
/*
  divider giving a one-cycle enable at the base-timer sampling rate.
  assumes pclk keeps running in both standby modes.
*/
`timescale 1ns/10ps
`include "port_irq_regs.vh"

module base_tick_gen (
  input  wire pclk,
  input  wire presetn,
  output reg  tick
);

  reg [`BT_CNT_W-1:0] cnt;

  // ----------------------------------------------------------------
  // divider
  // ----------------------------------------------------------------
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cnt  <= {`BT_CNT_W{1'b0}};
      tick <= 1'b0;
    end
    else if (cnt == `BT_DIV - 1)
    begin
      cnt  <= {`BT_CNT_W{1'b0}};
      tick <= 1'b1;
    end
    else
    begin
      cnt  <= cnt + 1'b1;
      tick <= 1'b0;
    end
  end

endmodule // base_tick_gen

// ### design/pin_edge_detect.v
/*
  one pin: filtered level tracker and edge qualifier.
  assumes pin is synchronous to pclk and tick is a one-cycle enable.
*/
`timescale 1ns/10ps
`include "port_irq_regs.vh"

module pin_edge_detect (
  input  wire       pclk,
  input  wire       presetn,
  input  wire       en,
  input  wire       tick,
  input  wire       pin,
  input  wire [1:0] mode,
  output reg        edge_evt
);

  reg       lvl;
  reg [2:0] cnt;

  // ----------------------------------------------------------------
  // filter and edge qualify
  // ----------------------------------------------------------------
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      lvl      <= 1'b0;
      cnt      <= 3'h0;
      edge_evt <= 1'b0;
    end
    else
    begin
      edge_evt <= 1'b0;
      if (!en)
      begin
        lvl <= pin;
        cnt <= 3'h0;
      end
      else if (tick)
      begin
        if (pin == lvl)
          cnt <= 3'h0;
        else if (cnt == `FILTER_LAST)
        begin
          lvl <= pin;
          cnt <= 3'h0;
          case (mode)
            `MODE_FALL: edge_evt <= ~pin;
            `MODE_RISE: edge_evt <= pin;
            `MODE_BOTH: edge_evt <= 1'b1;
            default:    edge_evt <= 1'b0;
          endcase
        end
        else
          cnt <= cnt + 3'h1;
      end
    end
  end

endmodule // pin_edge_detect

// ### design/port_edge_interrupt_detect.v
/*
  eight-pin port with per-pin edge interrupt detection, apb registers,
  sticky request flags and standby wake control.
  assumes pins synchronous to pclk; power controller drives standby
  inputs; cpu pulses irq_ack when it accepts the request.
*/
// Local design decision: register access over APB.
`timescale 1ns/10ps
`include "port_irq_regs.vh"

module port_edge_interrupt_detect (
  input  wire                pclk,
  input  wire                presetn,
  input  wire                psel,
  input  wire                penable,
  input  wire                pwrite,
  input  wire [`ADDR_W-1:0]  paddr,
  input  wire [31:0]         pwdata,
  output reg  [31:0]         prdata,
  output reg                 pready,
  output reg                 pslverr,
  input  wire [7:0]          pin_in,
  output reg  [7:0]          pin_out,
  output reg  [7:0]          pin_oe,
  input  wire                standby,
  input  wire                deep_standby_mode,
  input  wire                irq_ack,
  output reg                 irq_req,
  output reg                 wake_req,
  output reg                 idle_rc_osc,
  output reg  [1:0]          power_state
);

  reg  [7:0]  port_output_latch;
  reg  [7:0]  port_direction;
  reg  [7:0]  irq_pin_select;
  reg  [7:0]  sample_clock_select;
  reg  [7:0]  pin_irq_flags;
  reg  [7:0]  next_flags;
  reg  [7:0]  rd_byte;
  reg         rd_hit;
  reg  [1:0]  next_state;
  reg         next_wake;
  wire [7:0]  pin_evt;
  wire [7:0]  pin_en;
  wire [7:0]  wake_ok;
  wire        bt_tick;
  wire        wr_acc;
  wire [15:0] idx;

  assign idx    = paddr[17:2];
  assign wr_acc = psel & penable & pwrite & pready;

  // ----------------------------------------------------------------
  // sampling clocks
  // ----------------------------------------------------------------
  base_tick_gen u_bt (
    .pclk    (pclk),
    .presetn (presetn),
    .tick    (bt_tick)
  );

  // ----------------------------------------------------------------
  // per-pin detectors
  // ----------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < 8; g = g + 1)
    begin : g_pin
      assign pin_en[g] = irq_pin_select[g] &
                         ~(deep_standby_mode & ~sample_clock_select[g]);
      assign wake_ok[g] = pin_irq_flags[g] &
                          ({port_direction[g], port_output_latch[g]} != `MODE_NONE) &
                          ((power_state == `ST_STBY) |
                           ((power_state == `ST_DEEP) & sample_clock_select[g]));
      pin_edge_detect u_det (
        .pclk     (pclk),
        .presetn  (presetn),
        .en       (pin_en[g]),
        .tick     (sample_clock_select[g] ? bt_tick : 1'b1),
        .pin      (pin_in[g]),
        .mode     ({port_direction[g], port_output_latch[g]}),
        .edge_evt (pin_evt[g])
      );
    end
  endgenerate

  // ----------------------------------------------------------------
  // flag update
  // ----------------------------------------------------------------
  always @*
  begin
    next_flags = pin_irq_flags;
    if (wr_acc && !pslverr && idx == `IDX_PIN_IRQ_FLAGS)
      next_flags = pin_irq_flags & pwdata[7:0];
    next_flags = next_flags | (pin_evt & irq_pin_select);
  end

  // ----------------------------------------------------------------
  // read mux
  // ----------------------------------------------------------------
  always @*
  begin
    rd_byte = `RST_BYTE;
    rd_hit  = 1'b1;
    case (idx)
      `IDX_PORT_OUTPUT_LATCH:   rd_byte = port_output_latch;
      `IDX_PORT_PIN_INPUT:      rd_byte = pin_in;
      `IDX_PORT_DIRECTION:      rd_byte = port_direction;
      `IDX_IRQ_PIN_SELECT:      rd_byte = irq_pin_select;
      `IDX_SAMPLE_CLOCK_SELECT: rd_byte = sample_clock_select;
      `IDX_PIN_IRQ_FLAGS:       rd_byte = pin_irq_flags;
      `IDX_WAKE_STATUS:         rd_byte = {5'h00, idle_rc_osc, power_state};
      default:                  rd_hit  = 1'b0;
    endcase
    if (paddr[1:0] != `ADDR_LSB)
      rd_hit = 1'b0;
  end

  // ----------------------------------------------------------------
  // power state machine
  // ----------------------------------------------------------------
  always @*
  begin
    next_state = power_state;
    next_wake  = 1'b0;
    case (power_state)
      `ST_RUN:
      begin
        if (deep_standby_mode)
          next_state = `ST_DEEP;
        else if (standby)
          next_state = `ST_STBY;
      end
      `ST_STBY:
      begin
        if (|wake_ok)
        begin
          next_state = `ST_IDLE;
          next_wake  = 1'b1;
        end
      end
      `ST_DEEP:
      begin
        if (|wake_ok)
        begin
          next_state = `ST_IDLE;
          next_wake  = 1'b1;
        end
      end
      `ST_IDLE:
      begin
        if (irq_ack && irq_req)
          next_state = `ST_RUN;
      end
      default: next_state = `ST_RUN;
    endcase
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      port_output_latch   <= `RST_BYTE;
      port_direction      <= `RST_BYTE;
      irq_pin_select      <= `RST_BYTE;
      sample_clock_select <= `RST_BYTE;
      pin_irq_flags       <= `RST_BYTE;
      prdata              <= 32'h00000000;
      pready              <= 1'b0;
      pslverr             <= 1'b0;
      pin_out             <= `RST_BYTE;
      pin_oe              <= `RST_BYTE;
      irq_req             <= 1'b0;
      wake_req            <= 1'b0;
      idle_rc_osc         <= 1'b0;
      power_state         <= `ST_RUN;
    end
    else
    begin
      pready <= 1'b1;
      if (psel && !penable)
      begin
        prdata  <= pwrite ? 32'h00000000 : {24'h000000, rd_byte};
        pslverr <= ~rd_hit | (pwrite & (idx == `IDX_PORT_PIN_INPUT |
                                         idx == `IDX_WAKE_STATUS));
      end
      if (wr_acc && !pslverr)
      begin
        case (idx)
          `IDX_PORT_OUTPUT_LATCH:   port_output_latch   <= pwdata[7:0];
          `IDX_PORT_DIRECTION:      port_direction      <= pwdata[7:0];
          `IDX_IRQ_PIN_SELECT:      irq_pin_select      <= pwdata[7:0];
          `IDX_SAMPLE_CLOCK_SELECT: sample_clock_select <= pwdata[7:0];
          default:                  port_direction      <= port_direction;
        endcase
      end
      pin_irq_flags <= next_flags;
      irq_req       <= |next_flags;
      pin_out       <= port_output_latch;
      pin_oe        <= port_direction & ~irq_pin_select;
      power_state   <= next_state;
      wake_req      <= next_wake;
      if (next_wake)
        idle_rc_osc <= (power_state == `ST_STBY);
    end
  end

endmodule // port_edge_interrupt_detect

// ### sim/pin_source.sv
/*
  pin model: external devices driving the eight port pins.
  assumes levels move only at rising pclk edges, as the block expects.
*/
`timescale 1ns/10ps
module pin_source (
  input  wire       pclk,
  input  wire [7:0] lvl,
  output reg  [7:0] pin_in
);
  // pins follow the requested levels one edge later
  always @(posedge pclk)
    pin_in <= lvl;
endmodule // pin_source

// ### sim/port_edge_interrupt_detect_sva.sv
/*
  port-level checks of the port edge interrupt block.
  assumes binding to its top module; one clock domain.
*/
`timescale 1ns/10ps
`include "port_irq_regs.vh"
module port_edge_interrupt_detect_sva (
  input wire               pclk,
  input wire               presetn,
  input wire               psel,
  input wire               penable,
  input wire               pwrite,
  input wire [`ADDR_W-1:0] paddr,
  input wire               pready,
  input wire               pslverr,
  input wire               irq_ack,
  input wire               irq_req,
  input wire               wake_req,
  input wire               idle_rc_osc,
  input wire [1:0]         power_state
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  wire flag_wr = psel && pwrite && paddr == {`IDX_PIN_IRQ_FLAGS, `ADDR_LSB};

  chk_irq_sticky: assert property (irq_req && !flag_wr |=> irq_req)
    else $error("irq request fell without flag write");
  chk_zero_wait: assert property (psel && !penable |=> pready)
    else $error("pready low in access phase");
  chk_misalign_err: assert property (psel && !penable && paddr[1:0] != 2'h0 |=> pslverr)
    else $error("misaligned access not refused");
  chk_wake_pulse: assert property (wake_req |=> !wake_req)
    else $error("wake pulse longer than one cycle");
  chk_wake_idle: assert property (wake_req |-> power_state == `ST_IDLE)
    else $error("wake without idle state");
  chk_wake_flag: assert property (wake_req |-> irq_req)
    else $error("wake without pending flag");
  chk_ack_run: assert property (power_state == `ST_IDLE && irq_ack && irq_req
    |=> power_state == `ST_RUN)
    else $error("accepted request did not return to run");
  chk_stby_rc: assert property (wake_req && $past(power_state) == `ST_STBY
    |-> idle_rc_osc)
    else $error("standby wake not on rc oscillator");
  chk_deep_osc: assert property (wake_req && $past(power_state) == `ST_DEEP
    |-> !idle_rc_osc)
    else $error("deep standby wake changed oscillator");

  cover property (wake_req && idle_rc_osc);
  cover property (wake_req && !idle_rc_osc);
  cover property ($rose(irq_req));
endmodule // port_edge_interrupt_detect_sva

bind port_edge_interrupt_detect port_edge_interrupt_detect_sva port_edge_interrupt_detect_sva_i (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pready(pready), .pslverr(pslverr), .irq_ack(irq_ack),
  .irq_req(irq_req), .wake_req(wake_req), .idle_rc_osc(idle_rc_osc),
  .power_state(power_state));

// ### sim/port_edge_interrupt_detect_tb.sv
/*
  testbench: apb master, pin model, scenario tasks and verdict.
  assumes design files, pin model and checker compiled first.
*/
`timescale 1ns/10ps
`include "port_irq_regs.vh"
module port_edge_interrupt_detect_tb;
  localparam logic [15:0] LAT = `IDX_PORT_OUTPUT_LATCH;
  localparam logic [15:0] DIR = `IDX_PORT_DIRECTION;
  localparam logic [15:0] SEL = `IDX_IRQ_PIN_SELECT;
  localparam logic [15:0] SCK = `IDX_SAMPLE_CLOCK_SELECT;
  localparam logic [15:0] FLG = `IDX_PIN_IRQ_FLAGS;
  logic        pclk, presetn, psel, penable, pwrite, standby, deep, irq_ack, err;
  logic [17:0] paddr;
  logic [31:0] pwdata, prdata;
  logic        pready, pslverr, irq_req, wake_req, idle_rc_osc;
  logic [7:0]  pin_in, pin_out, pin_oe, lvl, q;
  logic [1:0]  power_state, lsb;
  int          error_cnt, num_checks, c;

  port_edge_interrupt_detect port_edge_interrupt_detect_i (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
    .standby(standby), .deep_standby_mode(deep), .irq_ack(irq_ack),
    .irq_req(irq_req), .wake_req(wake_req), .idle_rc_osc(idle_rc_osc),
    .power_state(power_state));
  pin_source pin_source_i (.pclk(pclk), .lvl(lvl), .pin_in(pin_in));

  initial
  begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end

  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task wrap_up;
    $display("checks %0d mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e)
    begin
      error_cnt++;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  endtask
  task apb(input logic w, input logic [15:0] idx, input logic [7:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {idx, lsb};
    pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1)
    begin
      error_cnt++;
      wrap_up;
    end
    q = prdata[7:0];
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task drive(input logic [7:0] v);
    @(posedge pclk);
    lvl <= v;
    @(posedge pclk);
    @(negedge pclk);
  endtask
  task wait_irq(input int lim);
    c = 0;
    while (irq_req !== 1'b1 && c < lim)
    begin
      @(negedge pclk);
      c++;
    end
  endtask
  task ack_clear(input logic [7:0] v);
    @(posedge pclk);
    standby <= 1'b0;
    deep <= 1'b0;
    irq_ack <= 1'b1;
    @(posedge pclk);
    irq_ack <= 1'b0;
    @(negedge pclk);
    chk("run", `ST_RUN, power_state);
    drive(v);
    repeat (20) @(negedge pclk);
    apb(1'b1, FLG, 8'h00);
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task t_regs;
    logic [15:0] idx [5];
    idx = '{LAT, DIR, SEL, SCK, FLG};
    foreach (idx[i])
    begin
      apb(1'b0, idx[i], 8'h00);
      chk("reset", 8'h00, q);
    end
    apb(1'b0, 16'h7f60, 8'h00);
    chk("unmapped", 1'b1, err);
    apb(1'b1, `IDX_PORT_PIN_INPUT, 8'h5a);
    chk("ro write", 1'b1, err);
    apb(1'b1, LAT, 8'h3c);
    apb(1'b0, LAT, 8'h00);
    chk("latch", 8'h3c, pin_out);
    chk("latch rd", 8'h3c, q);
  endtask
  task t_modes;
    logic [1:0] m;
    apb(1'b1, SEL, 8'h01);
    for (int i = 0; i < 4; i++)
    begin
      m = i[1:0];
      apb(1'b1, DIR, {7'h0, m[1]});
      apb(1'b1, LAT, {7'h0, m[0]});
      drive(8'h01);
      wait_irq(20);
      chk("rise", m[1], c < 20);
      if (c < 20)
        chk("delay", 1'b1, c >= 7 && c <= 15);
      apb(1'b1, FLG, 8'h00);
      drive(8'h00);
      wait_irq(20);
      chk("fall", m[0], c < 20);
      apb(1'b1, FLG, 8'h00);
    end
  endtask
  task t_map;
    apb(1'b1, DIR, 8'hff);
    apb(1'b1, LAT, 8'hff);
    apb(1'b1, SEL, 8'h5a);
    drive(8'hff);
    repeat (60) @(negedge pclk);
    apb(1'b0, FLG, 8'h00);
    chk("flags", 8'h5a, q);
    chk("oe", 8'ha5, pin_oe);
    apb(1'b0, `IDX_PORT_PIN_INPUT, 8'h00);
    chk("pin in", 8'hff, q);
    apb(1'b1, FLG, 8'h0f);
    apb(1'b0, FLG, 8'h00);
    chk("keep", 8'h0a, q);
    lsb = 2'h2;
    apb(1'b1, FLG, 8'h00);
    chk("misaligned", 1'b1, err);
    lsb = 2'h0;
    apb(1'b0, FLG, 8'h00);
    chk("no clear", 8'h0a, q);
    apb(1'b1, FLG, 8'h00);
    @(negedge pclk);
    chk("irq", 1'b0, irq_req);
    drive(8'h00);
    repeat (20) @(negedge pclk);
    apb(1'b1, FLG, 8'h00);
  endtask
  task t_stby;
    apb(1'b1, DIR, 8'h06);
    apb(1'b1, LAT, 8'h00);
    apb(1'b1, SEL, 8'h07);
    apb(1'b1, SCK, 8'h02);
    standby <= 1'b1;
    drive(8'h01);
    repeat (20) @(negedge pclk);
    chk("idle pin", `ST_STBY, power_state);
    drive(8'h05);
    wait_irq(20);
    @(negedge pclk);
    chk("wake", `ST_IDLE, power_state);
    chk("rc", 1'b1, idle_rc_osc);
    apb(1'b0, `IDX_WAKE_STATUS, 8'h00);
    chk("status", 8'h07, q);
    ack_clear(8'h00);
  endtask
  task t_deep;
    deep <= 1'b1;
    drive(8'h04);
    repeat (20) @(negedge pclk);
    chk("sys pin", `ST_DEEP, power_state);
    drive(8'h06);
    wait_irq(16 * `BT_DIV);
    chk("base", 1'b1, c >= 7 * `BT_DIV && c <= 15 * `BT_DIV);
    @(negedge pclk);
    chk("wake", `ST_IDLE, power_state);
    chk("osc", 1'b0, idle_rc_osc);
    ack_clear(8'h00);
  endtask

  initial
  begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 18'h0;
    pwdata = 32'h0;
    standby = 1'b0;
    deep = 1'b0;
    irq_ack = 1'b0;
    lvl = 8'h00;
    lsb = 2'h0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    repeat (2) @(posedge pclk);
    t_regs;
    t_modes;
    t_map;
    t_stby;
    t_deep;
    wrap_up;
  end
endmodule // port_edge_interrupt_detect_tb
